// [icb_pkg.sv]
// shared types and constants for the two-wire bus master and slave
package icb_pkg;
	typedef enum logic [1:0] {ICB_CMD_START, ICB_CMD_WRITE, ICB_CMD_READ, ICB_CMD_STOP} icb_cmd_t;
	typedef enum logic [1:0] {ICB_RATE_STD, ICB_RATE_FAST, ICB_RATE_FPLUS} icb_rate_t;
	localparam int ICB_CORE_CLK_HZ = 125_000_000;
	localparam int ICB_RATE_STD_BPS = 100_000;
	localparam int ICB_RATE_FAST_BPS = 400_000;
	localparam int ICB_RATE_FPLUS_BPS = 1_700_000;
	// quarter bit periods, rounded up so no phase is shorter than allowed
	localparam int ICB_QTR_STD = (ICB_CORE_CLK_HZ + 4 * ICB_RATE_STD_BPS - 1) / (4 * ICB_RATE_STD_BPS);
	localparam int ICB_QTR_FAST = (ICB_CORE_CLK_HZ + 4 * ICB_RATE_FAST_BPS - 1) / (4 * ICB_RATE_FAST_BPS);
	localparam int ICB_QTR_FPLUS = (ICB_CORE_CLK_HZ + 4 * ICB_RATE_FPLUS_BPS - 1) / (4 * ICB_RATE_FPLUS_BPS);
	localparam int ICB_QTR_W = 9;
	localparam int ICB_ADDR_W = 7;
	localparam logic [3:0] ICB_ACK_BIT = 4'h8;
	localparam logic [1:0] ICB_PH_LOW0 = 2'h0;
	localparam logic [1:0] ICB_PH_LOW1 = 2'h1;
	localparam logic [1:0] ICB_PH_HIGH0 = 2'h2;
	localparam logic [1:0] ICB_PH_HIGH1 = 2'h3;
	localparam logic [3:0] ICB_RSV_LO = 4'h0;
	localparam logic [3:0] ICB_RSV_HI = 4'hF;
	// addresses 0000xxx and 1111xxx are reserved: 16 of 128
	function automatic logic icb_addr_ok(input logic [ICB_ADDR_W-1:0] a);
		return (a[6:3] != ICB_RSV_LO) && (a[6:3] != ICB_RSV_HI);
	endfunction : icb_addr_ok
endpackage : icb_pkg

// [icb_bus_if.sv]
// two-wire open-drain bus joining master and slave
`timescale 1ns/1ps
`default_nettype none
interface icb_bus_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;
	// wired-and with pull-ups: a line is low only while someone drives low
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);
	modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
	modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : icb_bus_if
`default_nettype wire

// [icb_master.sv]
// bus master: builds start, stop and byte transfers from user commands
// Summary of operation
// - nodes only pull low or release lines
// - data changes only while clock low
// - start: data falls while clock high
// - stop: data rises while clock high
// - master opens with start, seven-bit address
// - direction bit follows: 0 write, 1 read
// - master releases data for address acknowledge
// - receiver holds data low through ninth pulse
// - roles after address follow direction bit
// - bytes shift most significant bit first
// - write: slave acknowledges every byte
// - read: master acknowledges all but last
// - read ends with nack, slave then idles
// - finish with stop or repeated start
// - on read, master receives after direction bit
// - on write, master transmits except acknowledge
// - sixteen reserved addresses, 112 usable
// - clock rates 100k, 400k, 1.7M
// - master clocks and sequences; slave only follows
// - two pulled-up lines, shared half duplex
`timescale 1ns/1ps
`default_nettype none
module icb_master (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire icb_pkg::icb_cmd_t cmd_i,
	input wire logic [7:0] data_i,
	input wire logic last_i,
	input wire icb_pkg::icb_rate_t rate_i,
	output logic cmd_ready_o,
	output logic done_o,
	output logic ack_o,
	output logic [7:0] rd_data_o,
	icb_bus_if.master bus
);
	import icb_pkg::*;

	typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} icb_mst_state_t;

	icb_mst_state_t state_r;
	logic [1:0] q_r;
	logic [ICB_QTR_W-1:0] cnt_r;
	logic [ICB_QTR_W-1:0] qtr_r;
	logic [3:0] bit_r;
	logic [8:0] tx_r;
	logic [8:0] rx_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic ready_r;
	logic done_r;
	logic ack_r;
	logic [7:0] rd_r;
	logic sda_s1_r;
	logic sda_s2_r;

	wire logic [ICB_QTR_W-1:0] qtr_sel;
	wire logic tick;
	wire logic take;
	wire logic [8:0] tx_load;

	assign qtr_sel = (rate_i == ICB_RATE_FPLUS) ? ICB_QTR_W'(ICB_QTR_FPLUS) :
		(rate_i == ICB_RATE_FAST) ? ICB_QTR_W'(ICB_QTR_FAST) : ICB_QTR_W'(ICB_QTR_STD);
	assign tick = (state_r != M_IDLE) && (cnt_r == qtr_r - ICB_QTR_W'(1));
	assign take = ready_r && cmd_valid_i;
	// ninth bit released for write ack; on read it is our own ack or nack
	assign tx_load = (cmd_i == ICB_CMD_READ) ? {8'hFF, last_i} : {data_i, 1'b1};

	// open drain: pin level driven is always low, enable decides
	assign bus.m_scl_o = 1'b0;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_scl_oe = scl_oe_r;
	assign bus.m_sda_oe = sda_oe_r;
	assign cmd_ready_o = ready_r;
	assign done_o = done_r;
	assign ack_o = ack_r;
	assign rd_data_o = rd_r;

	always_ff @(posedge core_clk_i)
	begin
		sda_s1_r <= bus.sda;
		sda_s2_r <= sda_s1_r;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= M_IDLE;
			q_r <= ICB_PH_LOW0;
			cnt_r <= '0;
			qtr_r <= ICB_QTR_W'(ICB_QTR_STD);
			bit_r <= '0;
			tx_r <= '1;
			rx_r <= '0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			ack_r <= 1'b0;
			rd_r <= '0;
		end
		else
		begin
			done_r <= 1'b0;
			if (take)
			begin
				ready_r <= 1'b0;
				qtr_r <= qtr_sel;
				cnt_r <= '0;
				q_r <= ICB_PH_LOW0;
				bit_r <= '0;
				tx_r <= tx_load;
				case (cmd_i)
					ICB_CMD_START:
					begin
						// clock is low or bus idle here, so releasing data is legal
						state_r <= M_START;
						sda_oe_r <= 1'b0;
					end
					ICB_CMD_WRITE, ICB_CMD_READ:
					begin
						state_r <= M_BITS;
						sda_oe_r <= ~tx_load[8];
					end
					default:
					begin
						state_r <= M_STOP;
						sda_oe_r <= 1'b1;
					end
				endcase
			end
			else if (state_r != M_IDLE)
			begin
				cnt_r <= tick ? '0 : cnt_r + ICB_QTR_W'(1);
				if (tick)
				begin
					q_r <= q_r + 2'h1;
					case (state_r)
						M_START:
						begin
							if (q_r == ICB_PH_LOW0)
								scl_oe_r <= 1'b0;
							else if (q_r == ICB_PH_LOW1)
								sda_oe_r <= 1'b1;
							else if (q_r == ICB_PH_HIGH1)
							begin
								scl_oe_r <= 1'b1;
								sda_oe_r <= ~tx_r[8];
								state_r <= M_BITS;
							end
						end
						M_BITS:
						begin
							if (q_r == ICB_PH_LOW1)
								scl_oe_r <= 1'b0;
							else if (q_r == ICB_PH_HIGH0)
								rx_r <= {rx_r[7:0], sda_s2_r};
							else if (q_r == ICB_PH_HIGH1)
							begin
								scl_oe_r <= 1'b1;
								if (bit_r == ICB_ACK_BIT)
								begin
									// clock left low so the next command may change data
									state_r <= M_IDLE;
									ready_r <= 1'b1;
									done_r <= 1'b1;
									ack_r <= ~rx_r[0];
									rd_r <= rx_r[8:1];
								end
								else
								begin
									bit_r <= bit_r + 4'h1;
									tx_r <= {tx_r[7:0], 1'b1};
									sda_oe_r <= ~tx_r[7];
								end
							end
						end
						default:
						begin
							if (q_r == ICB_PH_LOW0)
								scl_oe_r <= 1'b0;
							else if (q_r == ICB_PH_LOW1)
								sda_oe_r <= 1'b0;
							else if (q_r == ICB_PH_HIGH1)
							begin
								state_r <= M_IDLE;
								ready_r <= 1'b1;
								done_r <= 1'b1;
							end
						end
					endcase
				end
			end
		end
	end
endmodule : icb_master
`default_nettype wire

// [icb_slave.sv]
// bus slave: link logic on the link clock, user side on the core clock
`timescale 1ns/1ps
`default_nettype none
module icb_slave #(
	// arbitrary default address
	parameter logic [6:0] OWN_ADDR = 7'h2A
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic tx_load_i,
	input wire logic [7:0] tx_data_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	icb_bus_if.slave bus
);
	import icb_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TXACK} icb_slv_state_t;

	// core domain
	logic [7:0] tx_hold_r;
	logic tx_tog_r;
	logic [2:0] rx_tog_c_r;
	logic rx_valid_r;
	logic [7:0] rx_data_r;
	// link domain
	logic [1:0] lrst_r;
	logic [2:0] scl_l_r;
	logic [2:0] sda_l_r;
	logic [2:0] tx_tog_l_r;
	icb_slv_state_t st_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_sh_r;
	logic [7:0] tx_word_r;
	logic rw_r;
	logic sda_oe_r;
	logic [7:0] rx_word_r;
	logic rx_tog_r;

	wire logic lrst_n;
	wire logic scl_rise;
	wire logic scl_fall;
	wire logic start_det;
	wire logic stop_det;
	wire logic addr_hit;

	assign lrst_n = lrst_r[1];
	assign scl_rise = scl_l_r[1] & ~scl_l_r[2];
	assign scl_fall = ~scl_l_r[1] & scl_l_r[2];
	assign start_det = scl_l_r[1] & scl_l_r[2] & ~sda_l_r[1] & sda_l_r[2];
	assign stop_det = scl_l_r[1] & scl_l_r[2] & sda_l_r[1] & ~sda_l_r[2];
	assign addr_hit = (sh_r[7:1] == OWN_ADDR) && icb_addr_ok(OWN_ADDR);
	assign bus.s_sda_o = 1'b0;
	assign bus.s_sda_oe = sda_oe_r;
	assign rx_valid_o = rx_valid_r;
	assign rx_data_o = rx_data_r;

	// word held stable after its toggle moves, so the far side can take it
	always_ff @(posedge core_clk_i)
	begin
		rx_tog_c_r <= {rx_tog_c_r[1:0], rx_tog_r};
		if (!rst_n_i)
		begin
			tx_hold_r <= '1;
			tx_tog_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_data_r <= '0;
		end
		else
		begin
			rx_valid_r <= rx_tog_c_r[2] ^ rx_tog_c_r[1];
			if (rx_tog_c_r[2] ^ rx_tog_c_r[1])
				rx_data_r <= rx_word_r;
			if (tx_load_i)
			begin
				tx_hold_r <= tx_data_i;
				tx_tog_r <= ~tx_tog_r;
			end
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		lrst_r <= {lrst_r[0], rst_n_i};
		scl_l_r <= {scl_l_r[1:0], bus.scl};
		sda_l_r <= {sda_l_r[1:0], bus.sda};
		tx_tog_l_r <= {tx_tog_l_r[1:0], tx_tog_r};
	end

	always_ff @(posedge link_clk_i)
	begin
		if (!lrst_n)
		begin
			st_r <= S_IDLE;
			cnt_r <= '0;
			sh_r <= '0;
			tx_sh_r <= '1;
			tx_word_r <= '1;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rx_word_r <= '0;
			rx_tog_r <= 1'b0;
		end
		else
		begin
			if (tx_tog_l_r[2] ^ tx_tog_l_r[1])
				tx_word_r <= tx_hold_r;
			if (start_det)
			begin
				st_r <= S_ADDR;
				cnt_r <= '0;
				sda_oe_r <= 1'b0;
			end
			else if (stop_det)
			begin
				st_r <= S_IDLE;
				sda_oe_r <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (st_r == S_ADDR || st_r == S_RX)
				begin
					sh_r <= {sh_r[6:0], sda_l_r[1]};
					cnt_r <= cnt_r + 4'h1;
				end
				else if (st_r == S_TX)
				begin
					tx_sh_r <= {tx_sh_r[6:0], 1'b1};
					cnt_r <= cnt_r + 4'h1;
				end
				else if (st_r == S_TXACK)
					st_r <= sda_l_r[1] ? S_IDLE : S_AACK;
			end
			else if (scl_fall)
			begin
				case (st_r)
					S_ADDR:
					begin
						// count reaches eight only after the direction bit is in
						if (cnt_r == ICB_ACK_BIT)
						begin
							if (addr_hit)
							begin
								st_r <= S_AACK;
								rw_r <= sh_r[0];
								sda_oe_r <= 1'b1;
							end
							else
								st_r <= S_IDLE;
						end
					end
					S_RX:
					begin
						if (cnt_r == ICB_ACK_BIT)
						begin
							st_r <= S_RACK;
							sda_oe_r <= 1'b1;
							rx_word_r <= sh_r;
							rx_tog_r <= ~rx_tog_r;
						end
					end
					S_AACK, S_RACK:
					begin
						cnt_r <= '0;
						if (rw_r)
						begin
							st_r <= S_TX;
							tx_sh_r <= tx_word_r;
							sda_oe_r <= ~tx_word_r[7];
						end
						else
						begin
							st_r <= S_RX;
							sda_oe_r <= 1'b0;
						end
					end
					S_TX:
					begin
						if (cnt_r == ICB_ACK_BIT)
						begin
							st_r <= S_TXACK;
							sda_oe_r <= 1'b0;
						end
						else
							sda_oe_r <= ~tx_sh_r[7];
					end
					default:
						sda_oe_r <= sda_oe_r;
				endcase
			end
		end
	end
endmodule : icb_slave
`default_nettype wire

// [icb_bus_properties.sv]
// concurrent checks on the two-wire bus between master and slave
`timescale 1ns/1ps
`default_nettype none
module icb_bus_properties #(
	parameter logic [6:0] OWN_ADDR = 7'h2A
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q_r, sda_q_r, first_r, wr_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] byte_r;
	wire start_w = scl && scl_q_r && sda_q_r && !sda;
	wire rise_w = scl && !scl_q_r;
	wire ninth_w = rise_w && bit_cnt_r == 4'h8;
	wire own_w = byte_r[7:1] == OWN_ADDR && byte_r[7:4] != 4'h0 && byte_r[7:4] != 4'hF;
	// bit position on the wire, restarted by every start
	always_ff @(posedge core_clk_i)
	begin
		scl_q_r <= !rst_n_i || scl;
		sda_q_r <= !rst_n_i || sda;
		if (!rst_n_i || start_w)
			bit_cnt_r <= 4'h0;
		else if (rise_w)
			bit_cnt_r <= ninth_w ? 4'h0 : bit_cnt_r + 4'h1;
		first_r <= rst_n_i && (start_w || (first_r && !ninth_w));
		if (rise_w && !ninth_w)
			byte_r <= {byte_r[6:0], sda};
		if (ninth_w && first_r)
			wr_r <= !byte_r[0];
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_start; scl && scl_q_r && sda_q_r && !sda; endsequence
	sequence s_stop; scl && scl_q_r && !sda_q_r && sda; endsequence
	property p_open_drain; !m_scl_o && !m_sda_o && !s_sda_o; endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
	property p_slave_hold; scl && scl_q_r |-> $stable(s_sda_oe); endproperty
	a_slave_hold: assert property (p_slave_hold) else $error("slave moved data while clock high");
	property p_master_setup; scl && $changed(m_sda_oe) |-> $past(scl, 8); endproperty
	a_master_setup: assert property (p_master_setup) else $error("master moved data mid clock pulse");
	property p_start_hold; s_start |=> scl [*8]; endproperty
	a_start_hold: assert property (p_start_hold) else $error("clock fell too soon after start");
	property p_stop_idle; s_stop |=> (scl && sda) [*8]; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
	property p_scl_high_min; $fell(scl) |-> $past(scl, 8); endproperty
	a_scl_high_min: assert property (p_scl_high_min) else $error("clock high phase too short");
	property p_addr_release; ninth_w && first_r |-> !m_sda_oe; endproperty
	a_addr_release: assert property (p_addr_release) else $error("master held data in address ack");
	property p_addr_ack; ninth_w && first_r |-> s_sda_oe == own_w; endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
	property p_write_role; rise_w && !first_r && !ninth_w && wr_r |-> !s_sda_oe; endproperty
	a_write_role: assert property (p_write_role) else $error("slave drove write data");
	property p_read_role; rise_w && !first_r && !ninth_w && !wr_r |-> !m_sda_oe; endproperty
	a_read_role: assert property (p_read_role) else $error("master drove read data");
	property p_slave_pull; $rose(s_sda_oe) |-> ##[1:700] (scl && !sda); endproperty
	a_slave_pull: assert property (p_slave_pull) else $error("slave pull not clocked");
endmodule : icb_bus_properties
`default_nettype wire

// [test_i2c_bus_transaction_protocol.sv]
// self-checking bench: master and slave joined across the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module test_i2c_bus_transaction_protocol;
	import icb_pkg::*;
	logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
	logic cmd_valid = 1'b0, last = 1'b0, tx_load = 1'b0;
	icb_cmd_t cmd = ICB_CMD_START;
	icb_rate_t rate = ICB_RATE_FAST;
	logic [7:0] data = 8'h00, tx_data = 8'h00;
	logic cmd_ready, done, ack, rx_valid;
	logic [7:0] rd_data, rx_data, rx_last;
	logic [8:0] wire_r;
	int n_fail = 0, comparisons = 0, n_rx = 0;
	icb_bus_if bus ();
	icb_master icb_master_i (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.data_i(data), .last_i(last), .rate_i(rate), .cmd_ready_o(cmd_ready), .done_o(done), .ack_o(ack),
		.rd_data_o(rd_data), .bus(bus.master));
	icb_slave #(.OWN_ADDR(7'h2A)) icb_slave_i (.core_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
		.tx_load_i(tx_load), .tx_data_i(tx_data), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .bus(bus.slave));
	icb_bus_properties #(.OWN_ADDR(7'h2A)) icb_bus_properties_i (.core_clk_i(clk), .rst_n_i(rst_n),
		.m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
		.s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));
	initial forever #4 clk = ~clk;
	initial
	begin
		#17;
		forever #62.5 link_clk = ~link_clk;
	end
	// last nine bits seen on the wire, first in at the top
	always @(posedge bus.scl) wire_r <= {wire_r[7:0], bus.sda};
	// sampled off the launching edge so the registered pulse has settled
	always @(negedge clk)
		if (rx_valid === 1'b1)
		begin
			n_rx++;
			rx_last = rx_data;
		end
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic run(input icb_cmd_t c, input logic [7:0] d, input logic l, input icb_rate_t r);
		int n, q, e;
		q = r == ICB_RATE_STD ? ICB_QTR_STD : r == ICB_RATE_FAST ? ICB_QTR_FAST : ICB_QTR_FPLUS;
		e = q * (c == ICB_CMD_START ? 40 : c == ICB_CMD_STOP ? 4 : 36);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = c;
		data = d;
		last = l;
		rate = r;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
		chk("latency", 9'h1, 9'(n >= e && n <= e + 2));
		if (n >= 20000)
			tally_and_finish();
	endtask : run
	task automatic load(input logic [7:0] d);
		@(negedge clk);
		tx_data = d;
		tx_load = 1'b1;
		@(negedge clk);
		tx_load = 1'b0;
	endtask : load
	task automatic t_write;
		run(ICB_CMD_START, 8'h54, 1'b0, ICB_RATE_FAST);
		chk("addr ack", 9'h1, 9'(ack));
		chk("addr wire", {8'h54, 1'b0}, wire_r);
		run(ICB_CMD_WRITE, 8'hA5, 1'b0, ICB_RATE_FAST);
		chk("wr ack", 9'h1, 9'(ack));
		chk("wr wire", {8'hA5, 1'b0}, wire_r);
		chk("rx data", 9'hA5, 9'(rx_last));
		run(ICB_CMD_WRITE, 8'h3C, 1'b0, ICB_RATE_FAST);
		chk("wr ack", 9'h1, 9'(ack));
		run(ICB_CMD_STOP, 8'h00, 1'b0, ICB_RATE_FAST);
		chk("rx data", 9'h3C, 9'(rx_last));
		chk("rx count", 9'h2, 9'(n_rx));
		chk("idle", 9'h3, {7'h0, bus.sda, bus.scl});
	endtask : t_write
	task automatic t_read;
		load(8'h96);
		run(ICB_CMD_START, 8'h55, 1'b0, ICB_RATE_FAST);
		chk("addr ack", 9'h1, 9'(ack));
		repeat (8) @(posedge link_clk);
		load(8'h5B);
		run(ICB_CMD_READ, 8'h00, 1'b0, ICB_RATE_FAST);
		chk("rd data", 9'h96, 9'(rd_data));
		chk("rd ack", 9'h1, 9'(ack));
		run(ICB_CMD_READ, 8'h00, 1'b1, ICB_RATE_FAST);
		chk("rd data", 9'h5B, 9'(rd_data));
		chk("rd nack", 9'h0, 9'(ack));
		run(ICB_CMD_START, 8'h54, 1'b0, ICB_RATE_FAST);
		chk("restart ack", 9'h1, 9'(ack));
		run(ICB_CMD_WRITE, 8'h0F, 1'b0, ICB_RATE_FAST);
		chk("rx data", 9'h0F, 9'(rx_last));
		run(ICB_CMD_STOP, 8'h00, 1'b0, ICB_RATE_FAST);
	endtask : t_read
	task automatic t_ignore;
		int n0;
		n0 = n_rx;
		run(ICB_CMD_START, 8'h66, 1'b0, ICB_RATE_FAST);
		chk("foreign ack", 9'h0, 9'(ack));
		run(ICB_CMD_WRITE, 8'h11, 1'b0, ICB_RATE_FAST);
		chk("foreign wr", 9'h0, 9'(ack));
		chk("foreign rx", 9'(n0), 9'(n_rx));
		run(ICB_CMD_STOP, 8'h00, 1'b0, ICB_RATE_FPLUS);
	endtask : t_ignore
	task automatic t_std;
		run(ICB_CMD_START, 8'h54, 1'b0, ICB_RATE_STD);
		chk("std ack", 9'h1, 9'(ack));
		run(ICB_CMD_STOP, 8'h00, 1'b0, ICB_RATE_STD);
	endtask : t_std
	initial
	begin
		repeat (12) @(posedge link_clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_write();
		t_read();
		t_ignore();
		t_std();
		tally_and_finish();
	end
endmodule : test_i2c_bus_transaction_protocol
`default_nettype wire
